// File: i2c_host_model.sv
// Safety controller acting as I2C host
`timescale 1ns/10ps
module i2c_host_model (
  input wire clk,
  input wire sda_oe,
  output reg scl,
  output wire sda
);
  reg low_q = 1'b0;
  initial scl = 1'b1;
  // Pull-up unless a party pulls low
  assign sda = ~(low_q | sda_oe);
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bit_io(input b, output s);
    begin
      low_q <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      s = sda;
      tick(4);
      scl <= 1'b0;
      tick(4);
    end
  endtask
  task byte_io(input [7:0] tx, input m_ack, output [7:0] rx, output s_ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(tx[i], rx[i]);
      end
      bit_io(m_ack, s_ack);
    end
  endtask
  task start;
    begin
      low_q <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      low_q <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(4);
    end
  endtask
  task stop;
    begin
      low_q <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      low_q <= 1'b0;
      tick(4);
    end
  endtask
endmodule

// File: pin_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// File: sleep_entry_monitor.v
// Sleep-entry order check for channels 4-6 with latched fault interrupt
//
// Functional notes
// R01: Channels 4-6 expected sleep-entry order, 8-bit RW, E3-E5, reset zero.
// R02: Sleep sequence compares each expected order with its logged order.
// R03: Controller drives active request pin; high selects active mode.
// R04: Active request pin low takes the device into sleep mode.
// R05: Fault drives active-low interrupt, latched, not following live fault.
// R06: Interrupt flags clear only by host writing one; zero leaves them.
// R07: Flags stay set after fault disappears; never self-clear.
// R08: Every sequencing failure shows on the hardware interrupt output.
// R09: Every failure recorded in registers readable over I2C.
// R10: Power-up leaves expected order registers at their default values.
// R11: Logged order differing from expected sets fault flag and interrupt.
`timescale 1ns/10ps
`include "sleep_order_defines.vh"
module sleep_entry_monitor #(
  parameter [6:0] I2C_ADDR = 7'h30,
  parameter integer SLEEP_WINDOW = `SLEEP_WINDOW_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire active_request_pin,
  input wire [2:0] rail_good,
  input wire fault_irq_n_i,
  output reg fault_irq_n_o,
  output reg fault_irq_n_oe,
  output reg active_mode
);

  // ==========================================================
  // Pin synchronisers
  wire [2:0] hi_s;
  wire [3:0] lo_s;
  wire scl_s = hi_s[0];
  wire sda_s = hi_s[1];
  wire irq_line_s = hi_s[2];
  wire act_s = lo_s[0];
  wire [2:0] good_s = lo_s[3:1];

  pin_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_hi (
    .clk(clk),
    .rst_n(rst_n),
    .din({fault_irq_n_i, sda_i, scl_i}),
    .dout(hi_s)
  );

  pin_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_lo (
    .clk(clk),
    .rst_n(rst_n),
    .din({rail_good, active_request_pin}),
    .dout(lo_s)
  );

  // ==========================================================
  // I2C bus conditions
  reg scl_q;
  reg sda_q;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_PACK = 4'h4;
  localparam [3:0] ST_WR = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RD = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] shf_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rnw_q;
  reg nack_q;

  // ==========================================================
  // Register storage
  reg [7:0] exp_q [0:2];
  reg [7:0] log_q [0:2];
  reg [2:0] flags1_q;
  reg flag_to_q;
  reg run_q;
  reg [7:0] ord_q;
  reg [2:0] seen_q;
  reg [2:0] good_q;
  reg act_q;
  reg [19:0] tmr_q;

  // Host write strobe, issued on the falling edge after the eighth data bit
  wire wr_en = (st_q == ST_WR) && scl_fall && (cnt_q == 4'h8);

  // Read mux; unmapped offsets read zero
  reg [7:0] rd_data;
  always @* begin
    case (ptr_q)
      `OFS_EXP_CH4: rd_data = exp_q[0];
      `OFS_EXP_CH5: rd_data = exp_q[1];
      `OFS_EXP_CH6: rd_data = exp_q[2];
      `OFS_LOG_CH4: rd_data = log_q[0]; // [R09]
      `OFS_LOG_CH5: rd_data = log_q[1]; // [R09]
      `OFS_LOG_CH6: rd_data = log_q[2]; // [R09]
      `OFS_FLAGS_FIRST: rd_data = {5'h00, flags1_q}; // [R09]
      `OFS_FLAGS_SECOND: rd_data = {7'h00, flag_to_q}; // [R09]
      `OFS_STATUS: rd_data = {5'h00, irq_line_s, run_q, active_mode};
      default: rd_data = `RD_UNMAPPED;
    endcase
  end

  // ==========================================================
  // I2C slave state machine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shf_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= `RST_PTR;
      rnw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      sda_o <= 1'b0;
      if (bus_start) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        st_q <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise) begin
              shf_q <= {shf_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (shf_q[7:1] == I2C_ADDR) begin
                  rnw_q <= shf_q[0];
                  sda_oe <= 1'b1;
                  st_q <= ST_AACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else if (st_q == ST_PTR) begin
                ptr_q <= shf_q;
                sda_oe <= 1'b1;
                st_q <= ST_PACK;
              end else begin
                ptr_q <= ptr_q + 8'h01;
                sda_oe <= 1'b1;
                st_q <= ST_WACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rnw_q) begin
                tx_q <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                st_q <= ST_RD;
              end else begin
                sda_oe <= 1'b0;
                st_q <= ST_PTR;
              end
            end
          end
          ST_PACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              st_q <= ST_WR;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              st_q <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                cnt_q <= 4'h0;
                sda_oe <= 1'b0;
                st_q <= ST_RACK;
              end else begin
                sda_oe <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_s;
            end else if (scl_fall) begin
              if (nack_q) begin
                st_q <= ST_IDLE;
              end else begin
                tx_q <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                st_q <= ST_RD;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Mode, sleep-entry logging and order check
  wire seq_start = act_q & ~act_s;
  wire tmr_done = (tmr_q == 20'h00000);
  wire seq_end = run_q & ((&seen_q) | tmr_done);
  wire [2:0] drop = good_q & ~good_s & ~seen_q & {3{run_q}};

  // Mismatch per channel, evaluated at sequence end
  reg [2:0] mism;
  reg [2:0] wr_clr1;
  integer i;
  integer j;
  always @* begin
    mism = 3'h0;
    wr_clr1 = 3'h0;
    for (j = 0; j < 3; j = j + 1) begin
      if (seq_end && (exp_q[j] != log_q[j])) begin
        mism[j] = 1'b1; // [R02] [R11]
      end
    end
    if (wr_en && ptr_q == `OFS_FLAGS_FIRST) begin
      wr_clr1 = shf_q[2:0]; // [R06]
    end
  end

  wire wr_clr2 = wr_en && (ptr_q == `OFS_FLAGS_SECOND) &&
    shf_q[`FLG2_TIMEOUT];
  wire to_set = seq_end & tmr_done & ~(&seen_q);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_mode <= 1'b0;
      act_q <= 1'b0;
      good_q <= 3'h0;
      run_q <= 1'b0;
      ord_q <= 8'h00;
      seen_q <= 3'h0;
      tmr_q <= 20'h00000;
      flags1_q <= `RST_FLAGS;
      flag_to_q <= 1'b0;
      fault_irq_n_o <= 1'b0;
      fault_irq_n_oe <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        exp_q[i] <= `RST_EXP; // [R01] [R10]
        log_q[i] <= `RST_LOG;
      end
    end else begin
      act_q <= act_s;
      good_q <= good_s;
      active_mode <= act_s; // [R03] [R04]
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_en && ptr_q == (`OFS_EXP_CH4 + i[7:0])) begin
          exp_q[i] <= shf_q; // [R01]
        end
      end
      if (seq_start) begin
        run_q <= 1'b1; // [R04]
        ord_q <= 8'h00;
        seen_q <= 3'h0;
        tmr_q <= SLEEP_WINDOW[19:0] - 20'h1;
        for (i = 0; i < 3; i = i + 1) begin
          log_q[i] <= `RST_LOG;
        end
      end else if (run_q) begin
        if (seq_end) begin
          run_q <= 1'b0;
        end else begin
          tmr_q <= tmr_q - 20'h1;
        end
        if (|drop) begin
          ord_q <= ord_q + 8'h01;
        end
        seen_q <= seen_q | drop;
        for (i = 0; i < 3; i = i + 1) begin
          if (drop[i]) begin
            log_q[i] <= ord_q + 8'h01; // [R09]
          end
        end
      end
      // Set wins over a same-cycle clear; no other path clears
      flags1_q <= (flags1_q & ~wr_clr1) | mism; // [R06] [R07] [R11]
      flag_to_q <= (flag_to_q & ~wr_clr2) | to_set; // [R06] [R07]
      // Open-drain low while any flag is held
      fault_irq_n_oe <= (|flags1_q) | flag_to_q; // [R05] [R08]
    end
  end

endmodule

// File: sleep_entry_monitor_sva.sv
// Port checker for the sleep-entry order monitor
`timescale 1ns/10ps
module sleep_entry_monitor_sva #(
  parameter integer SLEEP_WINDOW = 1000000
) (
  input wire clk,
  input wire rst_n,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire active_request_pin,
  input wire [2:0] rail_good,
  input wire fault_irq_n_i,
  input wire fault_irq_n_o,
  input wire fault_irq_n_oe,
  input wire active_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  a_irq_data_low: assert property (!fault_irq_n_o)
    else $error("irq data not low");
  a_sda_data_low: assert property (!sda_o)
    else $error("sda data not low");
  a_mode_enter_act: assert property (
    $rose(active_request_pin) |-> ##[1:4] active_mode)
    else $error("active mode late");
  a_mode_enter_slp: assert property (
    $fell(active_request_pin) |-> ##[1:4] !active_mode)
    else $error("sleep mode late");
  a_irq_held_set: assert property (
    $fell(fault_irq_n_oe) |-> !scl_i && !$past(scl_i))
    else $error("irq dropped without host write");
  a_ack_on_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("sda pulled while scl high");
  a_sda_stable_hi: assert property (scl_i [*5] |-> $stable(sda_oe))
    else $error("sda moved during scl high");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !sda_oe && !fault_irq_n_oe && !active_mode)
    else $error("outputs active after reset");
  // ==========================================================
  // Coverage
  c_irq_raised: cover property ($rose(fault_irq_n_oe));
  c_irq_cleared: cover property ($fell(fault_irq_n_oe));
  c_sleep_entry: cover property ($fell(active_mode));
endmodule
bind sleep_entry_monitor sleep_entry_monitor_sva #(.SLEEP_WINDOW(SLEEP_WINDOW)) i_sva (
  .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .active_request_pin(active_request_pin),
  .rail_good(rail_good), .fault_irq_n_i(fault_irq_n_i),
  .fault_irq_n_o(fault_irq_n_o), .fault_irq_n_oe(fault_irq_n_oe),
  .active_mode(active_mode));

// File: sleep_entry_order_check_and_fault_irq_bench.sv
// Self-checking bench for the sleep-entry order monitor
`timescale 1ns/10ps
`include "sleep_order_defines.vh"
module sleep_entry_order_check_and_fault_irq_bench;
  localparam [6:0] ADDR = 7'h30;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg act = 1'b1;
  reg [2:0] rails = 3'h7;
  wire scl, sda, sda_oe, irq_oe, mode;
  wire irq_w = ~irq_oe;
  integer fails = 0;
  integer checked = 0;
  integer i, run, rnd;
  reg [7:0] v, f, x;
  reg irq_exp;
  reg [7:0] e [0:2];
  always #5 clk = ~clk;
  sleep_entry_monitor #(.I2C_ADDR(ADDR), .SLEEP_WINDOW(50)) i_dut (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .active_request_pin(act), .rail_good(rails),
    .fault_irq_n_i(irq_w), .fault_irq_n_o(), .fault_irq_n_oe(irq_oe),
    .active_mode(mode));
  i2c_host_model i_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ==========================================================
  // Checking and bus tasks
  task chk(input [8*8-1:0] nm, input [7:0] x, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("[FAIL] %0s exp %h got %h", nm, x, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] r;
    reg k;
    begin
      i_host.start;
      i_host.byte_io({ADDR, 1'b0}, 1'b1, r, k);
      chk("ack", 8'h00, {7'h0, k});
      i_host.byte_io(a, 1'b1, r, k);
      i_host.byte_io(d, 1'b1, r, k);
      i_host.stop;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    reg [7:0] r;
    reg k;
    begin
      i_host.start;
      i_host.byte_io({ADDR, 1'b0}, 1'b1, r, k);
      i_host.byte_io(a, 1'b1, r, k);
      i_host.start;
      i_host.byte_io({ADDR, 1'b1}, 1'b1, r, k);
      i_host.byte_io(8'hFF, 1'b1, d, k);
      i_host.stop;
    end
  endtask
  // Channel 6 logs zero when its rail never drops (m set)
  function [7:0] exp_flags(input [7:0] a, input [7:0] b, input [7:0] c,
    input m);
    exp_flags = {5'h0, c != (m ? 8'h00 : 8'h03), b != 8'h02, a != 8'h01};
  endfunction
  task wrap_up;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rnd = $urandom(32'hB86B);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    for (i = 0; i < 3; i = i + 1) begin
      rd(`OFS_EXP_CH4 + i[7:0], v);
      chk("exp_rst", `RST_EXP, v);
    end
    rd(8'h20, v);
    chk("unmapped", `RD_UNMAPPED, v);
    // Run 2 keeps channel 6 up so the sleep window times out
    for (run = 0; run < 3; run = run + 1) begin
      for (i = 0; i < 3; i = i + 1) begin
        e[i] = run ? ((i == 2) ? 8'hFF : $urandom % 4) : i[7:0] + 8'h01;
        wr(`OFS_EXP_CH4 + i[7:0], e[i]);
        rd(`OFS_EXP_CH4 + i[7:0], v);
        chk("exp_rw", e[i], v);
      end
      act <= 1'b0;
      repeat (10) @(posedge clk);
      chk("sleep", 8'h00, {7'h0, mode});
      for (i = 0; i < 3; i = i + 1) begin
        if (run < 2 || i < 2) begin
          rails[i] <= 1'b0;
        end
        repeat (6) @(posedge clk);
      end
      repeat (10) @(posedge clk);
      for (i = 0; i < 3; i = i + 1) begin
        x = (run == 2 && i == 2) ? 8'h00 : i[7:0] + 8'h01;
        rd(`OFS_LOG_CH4 + i[7:0], v);
        chk("logged", x, v);
      end
      f = exp_flags(e[0], e[1], e[2], run == 2);
      irq_exp = (f != 8'h00) || (run == 2);
      rd(`OFS_FLAGS_FIRST, v);
      chk("flags", f, v);
      rd(`OFS_FLAGS_SECOND, v);
      chk("flags2", {7'h0, run == 2}, v);
      rd(`OFS_STATUS, v);
      chk("status", {5'h0, ~irq_exp, 2'b00}, v);
      chk("irq", {7'h0, irq_exp}, {7'h0, ~irq_w});
      rails <= 3'h7;
      act <= 1'b1;
      repeat (10) @(posedge clk);
      chk("active", 8'h01, {7'h0, mode});
      wr(`OFS_FLAGS_FIRST, 8'h00);
      rd(`OFS_FLAGS_FIRST, v);
      chk("w1c_zero", f, v);
      rd(`OFS_FLAGS_SECOND, v);
      chk("w1c_hold", {7'h0, run == 2}, v);
      chk("irq_held", {7'h0, irq_exp}, {7'h0, irq_oe});
      wr(`OFS_FLAGS_FIRST, 8'h07);
      wr(`OFS_FLAGS_SECOND, 8'h01);
      rd(`OFS_FLAGS_FIRST, v);
      chk("w1c_one", 8'h00, v);
      rd(`OFS_FLAGS_SECOND, v);
      chk("w1c_two", 8'h00, v);
      chk("irq_clr", 8'h00, {7'h0, irq_oe});
    end
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails = fails + 1;
    wrap_up;
  end
endmodule

// File: sleep_order_defines.vh
// Register map, field positions, reset values and timing counts
`ifndef SLEEP_ORDER_DEFINES_VH
`define SLEEP_ORDER_DEFINES_VH

// ==========================================================
// Register offsets
`define OFS_EXP_CH4 8'hE3
`define OFS_EXP_CH5 8'hE4
`define OFS_EXP_CH6 8'hE5
`define OFS_LOG_CH4 8'hF3
`define OFS_LOG_CH5 8'hF4
`define OFS_LOG_CH6 8'hF5
`define OFS_FLAGS_FIRST 8'h10
`define OFS_FLAGS_SECOND 8'h11
`define OFS_STATUS 8'h12

// ==========================================================
// Reset values
`define RST_EXP 8'h00
`define RST_LOG 8'h00
`define RST_FLAGS 3'h0
`define RST_PTR 8'h00
`define RD_UNMAPPED 8'h00

// ==========================================================
// Field positions
`define FLG2_TIMEOUT 0
`define STS_ACTIVE 0
`define STS_SEQ_RUN 1
`define STS_IRQ_LINE 2

// ==========================================================
// Timing
`define CLK_MHZ 100
`define SLEEP_WINDOW_US 10000
`define SLEEP_WINDOW_CYC (`SLEEP_WINDOW_US * `CLK_MHZ)

`endif
